// ==== verilog/scs_pkg.sv ====
package scs_pkg;

    // ****************************************************************
    // register addresses
    // ****************************************************************
    localparam logic [7:0] SCS_CTRL_ADDR = 8'hF8;
    localparam logic [7:0] SCS_CFG_ADDR  = 8'hA1;
    localparam logic [7:0] SCS_RATE_ADDR = 8'hA2;
    localparam logic [7:0] SCS_DATA_ADDR = 8'hA3;

    // ****************************************************************
    // serial_configuration fields
    // ****************************************************************
    localparam int unsigned CFG_BUSY_BIT  = 7;
    localparam int unsigned CFG_ROLE_BIT  = 6;
    localparam int unsigned CFG_PHASE_BIT = 5;
    localparam int unsigned CFG_POL_BIT   = 4;
    localparam int unsigned CFG_SEL_BIT   = 3;
    localparam int unsigned CFG_PIN_BIT   = 2;
    localparam int unsigned CFG_SHE_BIT   = 1;
    localparam int unsigned CFG_RXE_BIT   = 0;
    localparam logic [7:0]  CFG_RESET     = 8'h07;

    // ****************************************************************
    // serial_control fields
    // ****************************************************************
    localparam int unsigned CTRL_DONE_BIT = 7;
    localparam int unsigned CTRL_TXE_BIT  = 1;
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  RATE_RESET    = 8'h00;
    localparam logic [7:0]  DATA_RESET    = 8'h00;

    // ****************************************************************
    // word framing
    // ****************************************************************
    localparam logic [2:0] LAST_BIT_IDX = 3'h7;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic select_line;
    } scs_pins_t;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } scs_state_t;

endpackage

// ==== verilog/scs_pin_sync.sv ====
`timescale 1ns/1ns
module scs_pin_sync
    import scs_pkg::*;
(
    input  wire logic      ref_clk_i,
    input  wire logic      nrst_i,
    input  wire logic      ce_i,
    input  wire scs_pins_t pins_i,
    output scs_pins_t      raw_o,
    output scs_pins_t      stable_o
);

    scs_pins_t s1_reg;
    scs_pins_t s2_reg;
    scs_pins_t s3_reg;
    scs_pins_t st_reg;
    scs_pins_t st_next;

    // a bit is taken once stages two and three agree
    always_comb begin
        for (int i = 0; i < $bits(scs_pins_t); i++) begin
            st_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : st_reg[i];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
            st_reg <= '1;
        end else if (ce_i) begin
            s1_reg <= pins_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            st_reg <= st_next;
        end
    end

    assign raw_o    = s2_reg;
    assign stable_o = st_reg;

endmodule

// ==== verilog/scs_unit.sv ====
`timescale 1ns/1ns
module scs_unit
    import scs_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire scs_pins_t  pins_i,
    output logic            sck_o,
    output logic            sck_oe_o,
    output logic            mosi_o,
    output logic            mosi_oe_o,
    output logic            miso_o,
    output logic            miso_oe_o
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    scs_pins_t pin_raw;
    scs_pins_t pin_st;

    scs_pin_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .pins_i    (pins_i),
        .raw_o     (pin_raw),
        .stable_o  (pin_st)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic       en_reg,   en_next;
    logic       done_reg, done_next;
    logic       role_reg, role_next;
    logic       pha_reg,  pha_next;
    logic       pol_reg,  pol_next;
    logic [7:0] rate_reg, rate_next;
    logic [7:0] txb_reg,  txb_next;
    logic       txf_reg,  txf_next;
    logic [7:0] sh_reg,   sh_next;
    logic       ld_reg,   ld_next;
    logic [7:0] rxb_reg,  rxb_next;
    logic       rxf_reg,  rxf_next;
    logic [2:0] cnt_reg,  cnt_next;
    scs_state_t st_reg,   st_next;
    logic [7:0] div_reg,  div_next;
    logic       sck_reg,  sck_next;
    logic       smp_reg,  smp_next;
    logic       out_reg,  out_next;
    logic       sckoe_reg, sckoe_next;
    logic       misooe_reg, misooe_next;
    logic [7:0] rd_reg,   rd_next;
    logic       sckp_reg, sckp_next;
    logic       nssp_reg, nssp_next;

    logic       lead;
    logic       trail;
    logic       tick;
    logic       din;
    logic       nss_fall;
    logic       slv_act;
    logic       busy;
    logic       sh_empty;
    logic       rx_empty;
    logic [7:0] cfg_val;

    // ****************************************************************
    // edge decode
    // ****************************************************************
    always_comb begin
        tick     = (st_reg == ST_RUN) && role_reg && (div_reg == rate_reg);
        slv_act  = en_reg && !role_reg && !pin_st.select_line;
        nss_fall = nssp_reg && !pin_st.select_line;
        if (role_reg) begin
            lead  = tick && (sck_reg == pol_reg);
            trail = tick && (sck_reg != pol_reg);
        end else begin
            lead  = slv_act && (pin_st.sck != sckp_reg) && (sckp_reg == pol_reg);
            trail = slv_act && (st_reg == ST_RUN) && (pin_st.sck != sckp_reg)
                    && (sckp_reg != pol_reg);
        end
        din      = role_reg ? pin_st.miso : pin_st.mosi;
        busy     = (st_reg == ST_RUN);
        sh_empty = !ld_reg && !txf_reg;
        rx_empty = role_reg ? 1'b1 : !rxf_reg;
        cfg_val  = {busy, role_reg, pha_reg, pol_reg,
                    !pin_raw.select_line, pin_raw.select_line, sh_empty, rx_empty};
    end

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        en_next     = en_reg;
        done_next   = done_reg;
        role_next   = role_reg;
        pha_next    = pha_reg;
        pol_next    = pol_reg;
        rate_next   = rate_reg;
        txb_next    = txb_reg;
        txf_next    = txf_reg;
        sh_next     = sh_reg;
        ld_next     = ld_reg;
        rxb_next    = rxb_reg;
        rxf_next    = rxf_reg;
        cnt_next    = cnt_reg;
        st_next     = st_reg;
        div_next    = div_reg;
        sck_next    = sck_reg;
        smp_next    = smp_reg;
        out_next    = out_reg;
        rd_next     = rd_reg;
        sckp_next   = pin_st.sck;
        nssp_next   = pin_st.select_line;

        // register reads; a data read frees the receive holding buffer
        if (sfr_rd_i) begin
            if (hit(sfr_addr_i, SCS_CFG_ADDR)) begin
                rd_next = cfg_val;
            end else if (hit(sfr_addr_i, SCS_CTRL_ADDR)) begin
                rd_next = {done_reg, 5'h00, !txf_reg, en_reg};
            end else if (hit(sfr_addr_i, SCS_RATE_ADDR)) begin
                rd_next = rate_reg;
            end else if (hit(sfr_addr_i, SCS_DATA_ADDR)) begin
                rd_next  = rxb_reg;
                rxf_next = 1'b0;
            end else begin
                rd_next = 8'h00;
            end
        end

        // register writes
        if (sfr_wr_i) begin
            if (hit(sfr_addr_i, SCS_CFG_ADDR)) begin
                role_next = sfr_wdata_i[CFG_ROLE_BIT];
                pha_next  = sfr_wdata_i[CFG_PHASE_BIT];
                pol_next  = sfr_wdata_i[CFG_POL_BIT];
            end else if (hit(sfr_addr_i, SCS_CTRL_ADDR)) begin
                en_next = sfr_wdata_i[CTRL_EN_BIT];
                if (!sfr_wdata_i[CTRL_DONE_BIT]) begin
                    done_next = 1'b0;
                end
            end else if (hit(sfr_addr_i, SCS_RATE_ADDR)) begin
                rate_next = sfr_wdata_i;
            end else if (hit(sfr_addr_i, SCS_DATA_ADDR) && !txf_reg) begin
                txb_next = sfr_wdata_i;
                txf_next = 1'b1;
            end
        end

        // move a pending word into an idle shifter
        if ((st_reg == ST_IDLE) && !ld_reg && txf_reg) begin
            sh_next  = txb_reg;
            ld_next  = 1'b1;
            txf_next = 1'b0;
        end

        case (st_reg)
            ST_IDLE: begin
                div_next = 8'h00;
                sck_next = pol_next;
                if (en_reg && role_reg && ld_reg) begin
                    st_next = ST_RUN;
                end else if (lead) begin
                    st_next  = ST_RUN;
                    smp_next = din;
                end
            end
            ST_RUN: begin
                if (role_reg) begin
                    div_next = tick ? 8'h00 : div_reg + 8'h01;
                    if (tick) begin
                        sck_next = !sck_reg;
                    end
                end
                if (lead) begin
                    smp_next = din;
                end
                if (trail) begin
                    sh_next  = {sh_reg[6:0], pha_reg ? din : smp_reg};
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == LAST_BIT_IDX) begin
                        st_next   = ST_IDLE;
                        ld_next   = 1'b0;
                        done_next = 1'b1;
                        // a data read in this same cycle frees the buffer, so the word is kept
                        if (!rxf_next) begin
                            rxb_next = {sh_reg[6:0], pha_reg ? din : smp_reg};
                            rxf_next = 1'b1;
                        end
                    end
                end
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase

        // a peripheral moves on as soon as its sampling edge is seen: the
        // synchronisers eat most of a half period, so waiting longer is too late
        if (role_reg != pha_reg) begin
            out_next = sh_next[7];
        end else if (role_reg) begin
            if (lead || (st_reg == ST_IDLE)) begin
                out_next = sh_reg[7];
            end
        end else if (lead) begin
            out_next = sh_reg[6];
        end else if (st_reg == ST_IDLE) begin
            out_next = sh_next[7];
        end

        // leaving select or disabling drops a partial word
        if (!en_reg || (!role_reg && (nss_fall || pin_st.select_line))) begin
            st_next  = ST_IDLE;
            cnt_next = 3'h0;
        end

        sckoe_next  = en_next && role_next;
        misooe_next = en_reg && !role_reg && !pin_st.select_line;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            en_reg     <= CTRL_RESET[CTRL_EN_BIT];
            done_reg   <= CTRL_RESET[CTRL_DONE_BIT];
            role_reg   <= CFG_RESET[CFG_ROLE_BIT];
            pha_reg    <= CFG_RESET[CFG_PHASE_BIT];
            pol_reg    <= CFG_RESET[CFG_POL_BIT];
            rate_reg   <= RATE_RESET;
            txb_reg    <= DATA_RESET;
            txf_reg    <= 1'b0;
            sh_reg     <= DATA_RESET;
            ld_reg     <= 1'b0;
            rxb_reg    <= DATA_RESET;
            rxf_reg    <= 1'b0;
            cnt_reg    <= 3'h0;
            st_reg     <= ST_IDLE;
            div_reg    <= 8'h00;
            sck_reg    <= CFG_RESET[CFG_POL_BIT];
            smp_reg    <= 1'b0;
            out_reg    <= 1'b0;
            sckoe_reg  <= 1'b0;
            misooe_reg <= 1'b0;
            rd_reg     <= 8'h00;
            sckp_reg   <= 1'b1;
            nssp_reg   <= 1'b1;
        end else if (ce_i) begin
            en_reg     <= en_next;
            done_reg   <= done_next;
            role_reg   <= role_next;
            pha_reg    <= pha_next;
            pol_reg    <= pol_next;
            rate_reg   <= rate_next;
            txb_reg    <= txb_next;
            txf_reg    <= txf_next;
            sh_reg     <= sh_next;
            ld_reg     <= ld_next;
            rxb_reg    <= rxb_next;
            rxf_reg    <= rxf_next;
            cnt_reg    <= cnt_next;
            st_reg     <= st_next;
            div_reg    <= div_next;
            sck_reg    <= sck_next;
            smp_reg    <= smp_next;
            out_reg    <= out_next;
            sckoe_reg  <= sckoe_next;
            misooe_reg <= misooe_next;
            rd_reg     <= rd_next;
            sckp_reg   <= sckp_next;
            nssp_reg   <= nssp_next;
        end
    end

    assign sfr_rdata_o = rd_reg;
    assign sck_o       = sck_reg;
    assign sck_oe_o    = sckoe_reg;
    assign mosi_o      = out_reg;
    assign mosi_oe_o   = sckoe_reg;
    assign miso_o      = out_reg;
    assign miso_oe_o   = misooe_reg;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence cfg_read_s;
        ce_i && sfr_rd_i && hit(sfr_addr_i, SCS_CFG_ADDR);
    endsequence

    sequence last_edge_s;
        ce_i && trail && (cnt_reg == LAST_BIT_IDX) && !nss_fall && en_reg;
    endsequence

    rate_decode_a: assert property (
        ce_i && sfr_wr_i && hit(sfr_addr_i, SCS_RATE_ADDR)
        |=> rate_reg == $past(sfr_wdata_i))
        else $error("rate register write lost");
    busy_read_a: assert property (
        cfg_read_s |=> sfr_rdata_o[CFG_BUSY_BIT] == $past(st_reg == ST_RUN))
        else $error("busy bit wrong");
    idle_level_a: assert property (
        (st_reg == ST_IDLE) && sck_oe_o |-> sck_o == pol_reg)
        else $error("idle clock level wrong");
    sel_flag_a: assert property (
        cfg_read_s |=> sfr_rdata_o[CFG_SEL_BIT] == !$past(pin_raw.select_line))
        else $error("selected flag wrong");
    pin_level_a: assert property (
        cfg_read_s |=> sfr_rdata_o[CFG_PIN_BIT] == $past(pin_raw.select_line))
        else $error("select level bit wrong");
    word_end_a: assert property (
        last_edge_s |=> (st_reg == ST_IDLE) && !ld_reg && done_reg)
        else $error("word did not finish after eighth edge");
    role_drive_a: assert property (
        ce_i && en_reg && role_reg && !sfr_wr_i |=> sck_oe_o && !miso_oe_o)
        else $error("controller role not driving clock");
    phase_shift_a: assert property (
        ce_i && trail && !pha_reg && (st_reg == ST_RUN) && en_reg
        && (role_reg || !nss_fall) |=> sh_reg[0] == $past(smp_reg))
        else $error("phase 0 shift took wrong bit");
    sel_fall_a: assert property (
        ce_i && nss_fall && !role_reg |=> (cnt_reg == 3'h0) && (st_reg == ST_IDLE))
        else $error("select fall did not clear counter");

endmodule

// ==== bench/scs_peer.sv ====
`timescale 1ns/1ns
// ********
// far-side serial party: controller tasks, or armed peripheral
// ********
module scs_peer (
    input  wire logic sck_i,
    input  wire logic mosi_i,
    input  wire logic miso_i,
    output logic      sck_o,
    output logic      mosi_o,
    output logic      nss_o,
    output logic      miso_o,
    output logic      miso_oe_o
);
    localparam int HALF = 40;
    logic       slv_on;
    logic [7:0] slv_tx;
    logic [7:0] slv_rx;

    assign miso_o    = slv_tx[7];
    assign miso_oe_o = slv_on;

    initial begin
        sck_o  = 1'b0;
        mosi_o = 1'b0;
        nss_o  = 1'b1;
        slv_on = 1'b0;
        slv_tx = 8'h00;
        slv_rx = 8'h00;
    end

    // armed peripheral, phase 0 polarity 0 only
    always @(posedge sck_i) if (slv_on) slv_rx <= {slv_rx[6:0], mosi_i};
    always @(negedge sck_i) if (slv_on) slv_tx <= {slv_tx[6:0], 1'b0};

    task automatic arm(input logic [7:0] b);
        slv_tx = b;
        slv_rx = 8'h00;
        slv_on = 1'b1;
    endtask

    task automatic disarm();
        slv_on = 1'b0;
    endtask

    task automatic set_nss(input logic v);
        nss_o = v;
    endtask

    // sends n bits msb first; offset keeps edges off the system clock edge
    task automatic mxfer(input logic [7:0] tx, input int n, input logic ph,
                         input logic pol, output logic [7:0] rx);
        rx = 8'h00;
        #3;
        sck_o = pol;
        #HALF;
        nss_o = 1'b0;
        #60;
        for (int i = 7; i > 7 - n; i--) begin
            if (!ph) mosi_o = tx[i];
            #HALF;
            sck_o = ~pol;
            if (ph) mosi_o = tx[i];
            else rx = {rx[6:0], miso_i};
            #HALF;
            sck_o = pol;
            if (ph) rx = {rx[6:0], miso_i};
        end
        #HALF;
        nss_o  = 1'b1;
        mosi_o = ~mosi_o;
    endtask
endmodule

// ==== bench/test_spi_config_status.sv ====
`timescale 1ns/1ns
module test_spi_config_status
    import scs_pkg::*;
();
    typedef struct {
        logic [7:0] cfg;
        logic [7:0] exp;
        logic       oe;
        logic       sck;
    } scs_row_t;

    logic       clk, nrst, wr, rd, ce;
    logic [7:0] addr, wdata, rdata, v, got;
    logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic       p_sck, p_mosi, p_nss, p_miso, p_miso_oe;
    logic       sck_w, mosi_w, miso_w;
    scs_pins_t  pins;
    int         fail_count = 0;
    int         n_checks = 0;
    scs_row_t   rows [6] = '{'{8'h00, 8'h07, 1'b0, 1'b0}, '{8'h40, 8'h47, 1'b1, 1'b0},
                             '{8'h50, 8'h57, 1'b1, 1'b1}, '{8'h60, 8'h67, 1'b1, 1'b0},
                             '{8'hFF, 8'h77, 1'b1, 1'b1}, '{8'h30, 8'h37, 1'b0, 1'b0}};

    assign sck_w  = sck_oe ? sck_o : p_sck;
    assign mosi_w = mosi_oe ? mosi_o : p_mosi;
    assign miso_w = miso_oe ? miso_o : (p_miso_oe ? p_miso : 1'b1);
    assign pins   = '{sck: sck_w, mosi: mosi_w, miso: miso_w, select_line: p_nss};

    scs_unit uut (.ref_clk_i(clk), .nrst_i(nrst), .ce_i(ce), .sfr_addr_i(addr),
                  .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
                  .pins_i(pins), .sck_o(sck_o), .sck_oe_o(sck_oe), .mosi_o(mosi_o),
                  .mosi_oe_o(mosi_oe), .miso_o(miso_o), .miso_oe_o(miso_oe));

    scs_peer peer (.sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(p_sck),
                   .mosi_o(p_mosi), .nss_o(p_nss), .miso_o(p_miso), .miso_oe_o(p_miso_oe));

    always #5 clk = ~clk;

    // ********
    // shared tasks
    // ********
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        $display("watchdog expired");
        close_out();
    end

    // ********
    // main sequence
    // ********
    initial begin
        clk = 1'b0;
        ce = 1'b1;
        nrst = 1'b0;
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(SCS_CFG_ADDR, v);
        chk8(v, CFG_RESET);
        rd_reg(8'h00, v);
        chk8(v, 8'h00);
        $display("reset test done");
        wr_reg(SCS_CTRL_ADDR, 8'h01);
        foreach (rows[i]) begin
            wr_reg(SCS_CFG_ADDR, rows[i].cfg);
            rd_reg(SCS_CFG_ADDR, v);
            chk8(v, rows[i].exp);
            chk1(sck_oe, rows[i].oe);
            if (rows[i].oe) chk1(sck_o, rows[i].sck);
        end
        $display("table test done");
        wr_reg(SCS_CFG_ADDR, 8'h00);
        peer.set_nss(1'b0);
        repeat (6) @(posedge clk);
        rd_reg(SCS_CFG_ADDR, v);
        chk8(v, 8'h0B);
        chk1(miso_oe, 1'b1);
        peer.set_nss(1'b1);
        repeat (6) @(posedge clk);
        rd_reg(SCS_CFG_ADDR, v);
        chk8(v, 8'h07);
        chk1(miso_oe, 1'b0);
        $display("select test done");
        for (int m = 0; m < 4; m++) begin
            wr_reg(SCS_CFG_ADDR, 8'(m << 4));
            wr_reg(SCS_DATA_ADDR, 8'h96 ^ 8'(m));
            fork
                peer.mxfer(8'h5A + 8'(m), 8, m[1], m[0], got);
                begin
                    repeat (40) @(posedge clk);
                    rd_reg(SCS_CFG_ADDR, v);
                end
            join
            chk8(v & 8'h82, 8'h80);
            chk8(got, 8'h96 ^ 8'(m));
            rd_reg(SCS_DATA_ADDR, v);
            chk8(v, 8'h5A + 8'(m));
        end
        $display("peripheral modes test done");
        wr_reg(SCS_CFG_ADDR, 8'h00);
        wr_reg(SCS_DATA_ADDR, 8'hC3);
        peer.mxfer(8'hFF, 3, 1'b0, 1'b0, got);
        peer.mxfer(8'h24, 8, 1'b0, 1'b0, got);
        rd_reg(SCS_DATA_ADDR, v);
        chk8(v, 8'h24);
        rd_reg(SCS_CFG_ADDR, v);
        chk8(v, 8'h07);
        $display("abort test done");
        wr_reg(SCS_RATE_ADDR, 8'h04);
        wr_reg(SCS_CFG_ADDR, 8'h40);
        wr_reg(SCS_CTRL_ADDR, 8'h01);
        peer.arm(8'h3C);
        wr_reg(SCS_DATA_ADDR, 8'hA5);
        repeat (6) @(posedge clk);
        rd_reg(SCS_CFG_ADDR, v);
        chk8(v & 8'h82, 8'h80);
        for (int k = 0; k < 100; k++) begin
            rd_reg(SCS_CTRL_ADDR, v);
            if (v[7] === 1'b1) break;
        end
        chk8(v, 8'h83);
        rd_reg(SCS_CFG_ADDR, v);
        chk8(v, 8'h47);
        chk1(sck_o, 1'b0);
        rd_reg(SCS_DATA_ADDR, v);
        chk8(v, 8'h3C);
        chk8(peer.slv_rx, 8'hA5);
        peer.disarm();
        wr_reg(SCS_CTRL_ADDR, 8'h01);
        rd_reg(SCS_CTRL_ADDR, v);
        chk8(v, 8'h03);
        rd_reg(SCS_RATE_ADDR, v);
        chk8(v, 8'h04);
        $display("controller test done");
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(SCS_RATE_ADDR, 8'h09);
        ce <= 1'b1;
        rd_reg(SCS_RATE_ADDR, v);
        chk8(v, 8'h04);
        $display("clock enable test done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(SCS_CFG_ADDR, v);
        chk8(v, CFG_RESET);
        chk1(sck_oe, 1'b0);
        $display("second reset test done");
        close_out();
    end
endmodule
